// ==== logic/ahp_pkg.sv ====
// Package: constants and types for the converter host port and power control
package ahp_pkg;
  localparam int RES_W = 12;
  localparam int CHAN_W = 3;
  // Output codes at key input points
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_MID_M1 = 12'h7ff;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  localparam real LSB_MV = 1.2207;
  // Conversion timing in conversion-clock half cycles: 13.5 and 2.5 cycles
  localparam int CONV_HALF = 27;
  localparam int SAMPLE_HALF = 5;
  // Discarded conversions after deep power-down
  localparam int DEEP_DISCARD = 10;
  // Reset values
  localparam logic [2:0] CHAN_RST = 3'h0;
  // Power state, one-hot
  typedef enum logic [2:0] {
    PWR_ON = 3'b001,
    PWR_LIGHT = 3'b010,
    PWR_DEEP = 3'b100
  } ahp_pwr_t;
  // Decode of select bits 1,0 at read-strobe rising edge; bit 2 ignored
  function automatic ahp_pwr_t ahp_pwr_decode(input logic [1:0] sel);
    ahp_pwr_t r;
    r = PWR_ON;
    if (sel[1])
    begin
      r = PWR_DEEP;
    end
    else if (sel[0])
    begin
      r = PWR_LIGHT;
    end
    return r;
  endfunction : ahp_pwr_decode
endpackage : ahp_pkg

// ==== logic/ahp_buf2.sv ====
// Two-entry valid/ready buffer for conversion results
`timescale 1ns/10ps
module ahp_buf2 #(
  parameter int WIDTH = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  // Handshake from occupancy
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage written by index
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= ~wr_q;
      end
      if (pop)
      begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule : ahp_buf2

// ==== logic/ahp_port.sv ====
// Host port: channel latch, conversion sequencing, result bus and power-down control
// Overview of operation
// - Channel select latched on convert strobe rising edge with chip select low.
// - Result is twelve-bit straight binary, 000 at zero, FFF at full scale.
// - Midscale code 800, one below 7FF, one step is 1.2207 mV.
// - Output bus driven only with chip select and read low after busy high.
// - Two power-down states: light keeps reference on, deep turns all off.
// - After deep state, flag first ten results invalid for discard.
// - After light state, results are valid immediately.
// - Enter chosen power-down state on read strobe rising edge after a read.
// - With chip select tied low, read strobe alone governs power-down.
// - Decode bits 1,0: 00 none, 01 light, 1x deep; bit 2 ignored.
// - Convert strobe falling with chip select low exits any power-down.
// - Conversion starts at first conversion-clock rising edge after strobe falls.
// - Conversion lasts 13.5 conversion-clock cycles, sampling 2.5 cycles.
// - Busy low during conversion, high at end with result valid.
`timescale 1ns/10ps
module ahp_port
  import ahp_pkg::*;
#(
  parameter int RES_WIDTH = RES_W,
  parameter int DISCARD_COUNT = DEEP_DISCARD
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic conv_clk,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [ahp_pkg::CHAN_W-1:0] chan_sel,
  output logic [ahp_pkg::CHAN_W-1:0] active_chan,
  output logic sample_req,
  input wire logic [RES_WIDTH-1:0] sar_code,
  input wire logic sar_code_valid,
  output logic sar_code_ready,
  output logic busy_n,
  output logic [RES_WIDTH-1:0] data_out,
  output logic data_oe,
  output logic result_valid,
  output logic ref_on,
  output logic core_on,
  output logic [2:0] pwr_state
);
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_WAIT = 3'b010,
    CV_RUN = 3'b100
  } ahp_cv_t;

  ahp_cv_t cv_q;
  ahp_pwr_t pwr_q;
  logic wr_n_q;
  logic rd_n_q;
  logic conv_clk_q;
  logic [5:0] half_q;
  logic [CHAN_W-1:0] chan_q;
  logic [RES_WIDTH-1:0] res_q;
  logic [3:0] discard_q;
  logic busy_n_q;
  logic fresh_q;
  logic clk_edge;
  logic wr_fall;
  logic wr_rise;
  logic rd_rise;
  logic conv_done;
  logic buf_valid;
  logic [RES_WIDTH-1:0] buf_data;

  // Edges of strobes and conversion clock, inputs taken as synchronous
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      conv_clk_q <= 1'b0;
    end
    else
    begin
      wr_n_q <= wr_n;
      rd_n_q <= rd_n;
      conv_clk_q <= conv_clk;
    end
  end
  assign clk_edge = conv_clk != conv_clk_q;
  assign wr_fall = wr_n_q && !wr_n && !cs_n;
  assign wr_rise = !wr_n_q && wr_n && !cs_n;
  assign rd_rise = !rd_n_q && rd_n && !cs_n;

  // Channel becomes active on convert strobe rising edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      chan_q <= CHAN_RST;
    end
    else if (wr_rise)
    begin
      chan_q <= chan_sel;
    end
  end

  // Conversion sequencer; half cycles counted on both conversion-clock edges
  assign conv_done = (cv_q == CV_RUN) && clk_edge && (half_q == 6'(CONV_HALF - 1));
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cv_q <= CV_IDLE;
      half_q <= 6'd0;
    end
    else
    begin
      unique case (cv_q)
        CV_IDLE:
        begin
          if (wr_fall)
          begin
            cv_q <= CV_WAIT;
          end
        end
        CV_WAIT:
        begin
          if (clk_edge && conv_clk)
          begin
            cv_q <= CV_RUN;
            half_q <= 6'd0;
          end
        end
        CV_RUN:
        begin
          if (clk_edge)
          begin
            half_q <= half_q + 6'd1;
          end
          if (conv_done)
          begin
            cv_q <= CV_IDLE;
          end
        end
      endcase
    end
  end
  assign sample_req = (cv_q == CV_RUN) && (half_q < 6'(SAMPLE_HALF));

  // Busy low from strobe fall until the result register is loaded,
  // so the bus never shows a stale code once busy is high
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      busy_n_q <= 1'b1;
    end
    else if (wr_fall)
    begin
      busy_n_q <= 1'b0;
    end
    else if (cv_q == CV_IDLE && fresh_q && buf_valid)
    begin
      busy_n_q <= 1'b1;
    end
  end
  assign busy_n = busy_n_q;

  // Core codes buffered so a late result is not lost if the core runs ahead
  ahp_buf2 #(
    .WIDTH(RES_WIDTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(sar_code_valid),
    .in_ready(sar_code_ready),
    .in_data(sar_code),
    .out_valid(buf_valid),
    .out_ready(fresh_q),
    .out_data(buf_data)
  );

  // Result register; straight binary passes through unchanged
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      res_q <= CODE_ZERO;
      fresh_q <= 1'b0;
    end
    else
    begin
      if (conv_done)
      begin
        fresh_q <= 1'b1;
      end
      else if (fresh_q && buf_valid)
      begin
        res_q <= buf_data;
        fresh_q <= 1'b0;
      end
    end
  end

  // Output bus enabled only while chip select and read strobe low and not busy
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      data_out <= CODE_ZERO;
      data_oe <= 1'b0;
    end
    else
    begin
      data_oe <= !cs_n && !rd_n && busy_n_q;
      data_out <= res_q;
    end
  end

  // Power state: read edge decodes, new conversion wakes; busy low blocks the decode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pwr_q <= PWR_ON;
    end
    else if (wr_fall)
    begin
      pwr_q <= PWR_ON;
    end
    else if (rd_rise && busy_n_q)
    begin
      pwr_q <= ahp_pwr_decode(chan_sel[1:0]);
    end
  end
  assign pwr_state = pwr_q;
  assign ref_on = (pwr_q != PWR_DEEP);
  assign core_on = (pwr_q == PWR_ON);

  // Discard window after deep state; light state needs none
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      discard_q <= 4'd0;
    end
    else if (wr_fall && pwr_q == PWR_DEEP)
    begin
      discard_q <= 4'(DISCARD_COUNT);
    end
    else if (conv_done && discard_q != 4'd0)
    begin
      discard_q <= discard_q - 4'd1;
    end
  end

  // Marks whether the current result may be trusted
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      result_valid <= 1'b0;
    end
    else if (conv_done)
    begin
      result_valid <= (discard_q == 4'd0);
    end
  end
  assign active_chan = chan_q;
endmodule : ahp_port

// ==== verif/ahp_sva.sv ====
// Concurrent checks on the converter host port
`timescale 1ns/10ps
module ahp_sva
  import ahp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic conv_clk,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [2:0] chan_sel,
  input wire logic [2:0] active_chan,
  input wire logic busy_n,
  input wire logic data_oe,
  input wire logic ref_on,
  input wire logic core_on,
  input wire logic [2:0] pwr_state
);
  logic clk_q;
  logic [5:0] chg_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Conversion clock changes while busy; cleared when idle
  always_ff @(posedge clk_sys)
  begin
    clk_q <= conv_clk;
    chg_q <= (reset || busy_n) ? 6'h0 : chg_q + 6'(conv_clk != clk_q);
  end
  // Idle read release, no start on the same edge
  sequence s_rd_rise;
    $rose(rd_n) && !cs_n && busy_n && wr_n;
  endsequence
  AST_NONE: assert property (s_rd_rise ##0 chan_sel[1:0] == 2'h0 |=> pwr_state == PWR_ON)
    else $error("no power-down select not taken");
  AST_LIGHT: assert property (s_rd_rise ##0 chan_sel[1:0] == 2'h1 |=> pwr_state == PWR_LIGHT)
    else $error("light power-down not entered");
  AST_DEEP: assert property (s_rd_rise ##0 chan_sel[1] |=> pwr_state == PWR_DEEP)
    else $error("deep power-down not entered");
  AST_WAKE: assert property ($fell(wr_n) && !cs_n |=> pwr_state == PWR_ON && !busy_n)
    else $error("start did not wake or raise busy");
  AST_CHAN: assert property ($rose(wr_n) && !cs_n |=> active_chan == $past(chan_sel))
    else $error("channel not latched");
  AST_OE: assert property (data_oe |-> !$past(cs_n) && !$past(rd_n) && $past(busy_n))
    else $error("output bus driven without read");
  AST_PWR: assert property (ref_on == (pwr_state != PWR_DEEP) && core_on == (pwr_state == PWR_ON))
    else $error("power enables disagree with state");
  AST_HOLD: assert property ($changed(pwr_state) |-> !$past(wr_n) || ($past(rd_n) && !$past(rd_n, 2)))
    else $error("power state moved without cause");
  AST_BUSYRD: assert property ($rose(rd_n) && !busy_n && wr_n |=> $stable(pwr_state))
    else $error("power select taken during conversion");
  AST_CONV: assert property ($rose(busy_n) |-> $past(chg_q) >= 6'd27)
    else $error("conversion ended too early");
endmodule : ahp_sva

// ==== verif/ahp_core_model.sv ====
// Behavioural conversion core answering each sample request
`timescale 1ns/10ps
module ahp_core_model
(
  input wire logic clk_sys,
  input wire logic sample_req,
  input wire logic slow,
  input wire logic [11:0] code_in,
  input wire logic sar_code_ready,
  output logic sar_code_valid,
  output logic [11:0] sar_code
);
  logic rdy;
  // One code per conversion, held until taken; inverted once released
  initial
  begin
    sar_code_valid = 1'b0;
    sar_code = 12'h5a5;
    forever
    begin
      @(posedge sample_req);
      repeat (slow ? 40 : 2) @(posedge clk_sys);
      #1 sar_code_valid = 1'b1;
      sar_code = code_in;
      do
      begin
        rdy = sar_code_ready;
        @(posedge clk_sys);
      end
      while (!rdy);
      #1 sar_code_valid = 1'b0;
      sar_code = ~code_in;
    end
  end
endmodule : ahp_core_model

// ==== verif/test_adc_host_port_power_control.sv ====
// Self-checking bench for the converter host port
`timescale 1ns/10ps
module test_adc_host_port_power_control;
  import ahp_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, conv_clk = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, slow = 1'b0;
  logic [2:0] chan_sel = 3'h0, ep = 3'h1, active_chan, pwr_state;
  logic [11:0] code = 12'h0, sar_code, data_out;
  logic [11:0] corner [4] = '{CODE_ZERO, CODE_FULL, CODE_MID, CODE_MID_M1};
  logic sample_req, sar_code_valid, sar_code_ready, busy_n, data_oe, result_valid, ref_on, core_on;
  logic [31:0] lfsr = 32'h7f7e;
  int bad_count = 0, samples_checked = 0, left = 0, n;
  // Short discard window keeps the run brief while still covering it
  localparam int DISCARD_TB = 2;
  always #2 clk_sys = ~clk_sys;
  // Slow conversion clock, one change every four cycles
  always
  begin
    repeat (4) @(posedge clk_sys);
    #1 conv_clk = ~conv_clk;
  end
  ahp_port #(
    .DISCARD_COUNT(DISCARD_TB)
  ) dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .conv_clk(conv_clk),
    .cs_n(cs_n),
    .wr_n(wr_n),
    .rd_n(rd_n),
    .chan_sel(chan_sel),
    .active_chan(active_chan),
    .sample_req(sample_req),
    .sar_code(sar_code),
    .sar_code_valid(sar_code_valid),
    .sar_code_ready(sar_code_ready),
    .busy_n(busy_n),
    .data_out(data_out),
    .data_oe(data_oe),
    .result_valid(result_valid),
    .ref_on(ref_on),
    .core_on(core_on),
    .pwr_state(pwr_state)
  );
  ahp_core_model core (
    .clk_sys(clk_sys),
    .sample_req(sample_req),
    .slow(slow),
    .code_in(code),
    .sar_code_ready(sar_code_ready),
    .sar_code_valid(sar_code_valid),
    .sar_code(sar_code)
  );
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [11:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[11:0];
  endfunction : rnd
  function automatic logic [2:0] pwr_of(logic [2:0] sel);
    return sel[1] ? 3'h4 : (sel[0] ? 3'h2 : 3'h1);
  endfunction : pwr_of
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // Start, stray read mid-conversion, result read, power request, hold
  task automatic conv(logic [11:0] c, logic [2:0] sel, logic [2:0] pd);
    int w;
    code = c;
    chan_sel = sel;
    wr_n = 1'b0;
    if (ep == 3'h4) left = DISCARD_TB;
    tick();
    chk("busy", 12'(busy_n), 12'h0);
    chk("wake", 12'(pwr_state), 12'h1);
    wr_n = 1'b1;
    tick();
    chk("chan", 12'(active_chan), 12'(sel));
    chan_sel = 3'h7;
    rd_n = 1'b0;
    tick(20);
    chk("oe_busy", 12'(data_oe), 12'h0);
    rd_n = 1'b1;
    tick(2);
    chk("pwr_busy", 12'(pwr_state), 12'h1);
    for (w = 0; w < 400 && busy_n !== 1'b1; w++) tick();
    if (w == 400)
    begin
      bad_count++;
      test_done();
    end
    chan_sel = pd;
    rd_n = 1'b0;
    tick(7);
    chk("oe", 12'(data_oe), 12'h1);
    chk("data", data_out, c);
    chk("valid", 12'(result_valid), 12'(left == 0));
    if (left > 0) left--;
    rd_n = 1'b1;
    tick(2);
    ep = pwr_of(pd);
    chk("pwr", 12'(pwr_state), 12'(ep));
    chk("ref_on", 12'(ref_on), 12'(ep != 3'h4));
    chk("core_on", 12'(core_on), 12'(ep == 3'h1));
    tick(1 + n % 8);
    chk("hold", 12'(pwr_state), 12'(ep));
  endtask : conv
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 reset = 1'b0;
    tick();
    // Start strobe with chip select high is ignored
    wr_n = 1'b0;
    tick(2);
    chk("busy_cs", 12'(busy_n), 12'h1);
    wr_n = 1'b1;
    cs_n = 1'b0;
    tick();
    for (n = 0; n < 16; n++)
    begin
      slow = n[2];
      conv(n < 4 ? corner[n] : rnd(), 3'(rnd()), n < 4 ? 3'(n) : 3'(rnd()));
    end
    test_done();
  end
endmodule : test_adc_host_port_power_control
bind ahp_port ahp_sva u_sva (
  .clk_sys(clk_sys),
  .reset(reset),
  .conv_clk(conv_clk),
  .cs_n(cs_n),
  .wr_n(wr_n),
  .rd_n(rd_n),
  .chan_sel(chan_sel),
  .active_chan(active_chan),
  .busy_n(busy_n),
  .data_oe(data_oe),
  .ref_on(ref_on),
  .core_on(core_on),
  .pwr_state(pwr_state)
);
